/* File: verilog/wio_sequencer.sv */
// Function
// - Ready no sooner than 1 s after diode power-on request.
// - End and judgment pulses last 20 ms, or 30/40 ms by setting.
// - Monitor error pulse lasts at least 1 ms.
// - Layout number 1 to 1023; zero means layout 1.
// - Layout number captured only on strobe rising edge.
// - Strobe honoured only while receivable and not emitting.
// - Host command or contact input switches control source.
// - Unregistered layout keeps the previous selection.
// - Scan start accepted after data error without error reset.
// - Closed select contact means external, open means panel.
// - Schedule and start must be stable for the acceptance time.
`include "wio_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wio_sequencer #(
    parameter int unsigned TICK_CYC = `WIO_TICK_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    input  wire wio_pkg::wio_pin_in_t  pin_i,
    output wio_pkg::wio_pin_out_t      pin_o,
    input  wire logic                  laser_emitting,
    input  wire logic                  shot_done,
    input  wire logic                  energy_high,
    input  wire logic                  energy_low,
    input  wire logic                  monitor_err,
    output logic                       scan_start_pulse
);

    function automatic logic [15:0] acc_ticks(input logic [2:0] sel);
        logic [15:0] t;
        t = 16'(`WIO_ACC_3_US / `WIO_TICK_US);
        case (sel)
            3'h0: t = 16'(`WIO_ACC_0_US / `WIO_TICK_US);
            3'h1: t = 16'(`WIO_ACC_1_US / `WIO_TICK_US);
            3'h2: t = 16'(`WIO_ACC_2_US / `WIO_TICK_US);
            3'h4: t = 16'(`WIO_ACC_4_US / `WIO_TICK_US);
            3'h5: t = 16'(`WIO_ACC_5_US / `WIO_TICK_US);
            default: t = 16'(`WIO_ACC_3_US / `WIO_TICK_US);
        endcase
        return t;
    endfunction : acc_ticks

    function automatic logic [15:0] ms_ticks(input int unsigned ms);
        return 16'(ms * `WIO_US_PER_MS / `WIO_TICK_US);
    endfunction : ms_ticks

    function automatic logic [15:0] width_ticks(input logic [1:0] sel);
        logic [15:0] t;
        t = ms_ticks(`WIO_PULSE_20_MS);
        case (sel)
            2'h1: t = ms_ticks(`WIO_PULSE_30_MS);
            2'h2: t = ms_ticks(`WIO_PULSE_40_MS);
            default: t = ms_ticks(`WIO_PULSE_20_MS);
        endcase
        return t;
    endfunction : width_ticks

    wio_pkg::wio_pin_in_t  sync1_q;
    wio_pkg::wio_pin_in_t  sync2_q;
    wio_pkg::wio_pin_out_t pin_o_q;
    wio_pkg::wio_lay_st_t  st_q;
    wio_pkg::wio_lay_st_t  st_d;
    logic [15:0]           tick_cnt_q;
    logic [31:0]           ctrl_q;
    logic [3:0]            irq_stat_q;
    logic [3:0]            irq_mask_q;
    logic [31:0]           prdata_q;
    logic [4:0]            filt_prev_q;
    logic [4:0]            filt_q;
    logic [15:0]           filt_cnt_q;
    logic                  start_prev_q;
    logic                  scan_start_q;
    logic                  diode_on_q;
    logic [15:0]           prep_cnt_q;
    logic [15:0]           end_cnt_q;
    logic [1:0]            judge_q;
    logic [15:0]           err_cnt_q;
    logic                  strobe_prev_q;
    logic [9:0]            clr_addr_q;
    logic [9:0]            pend_q;
    logic [9:0]            active_q;
    logic                  data_error_q;
    logic                  mem_rdata;

    // Timing base
    wire tick = tick_cnt_q == 16'(TICK_CYC - 1);

    // Control fields
    wire       host_src    = ctrl_q[`WIO_CTRL_HOST_SRC];
    wire       host_ext    = ctrl_q[`WIO_CTRL_HOST_EXT];
    wire       front_a_on  = ctrl_q[`WIO_CTRL_FRONT_DIODE];
    wire       scanner_layout_mode = ctrl_q[`WIO_CTRL_LAYOUT_MODE];
    wire [2:0] acc_sel  = ctrl_q[`WIO_CTRL_ACC_HI:`WIO_CTRL_ACC_LO];
    wire [1:0] wid_sel  = ctrl_q[`WIO_CTRL_WID_HI:`WIO_CTRL_WID_LO];

    // Host override, else closed contact means external
    wire ext_mode = host_src ? host_ext : sync2_q.ctrl_select;

    // One acceptance filter for schedule and start
    wire [4:0] filt_in  = {sync2_q.schedule, sync2_q.scan_start};
    wire       start_f  = filt_q[0];
    wire [3:0] sched_f  = filt_q[4:1];
    wire start_rise = ext_mode && start_f && !start_prev_q;

    // Diode and readiness
    wire diode_req  = ext_mode ? sync2_q.diode_power_request : front_a_on;
    wire prep_done  = diode_on_q && prep_cnt_q == 16'h0000;
    wire init_done  = st_q != wio_pkg::WIO_ST_CLEAR;
    wire ext_recv   = ext_mode && init_done;
    wire ready      = ext_recv && prep_done && !laser_emitting;

    // Layout strobe
    wire strobe_rise = sync2_q.layout_strobe && !strobe_prev_q;
    wire lay_accept  = strobe_rise && st_q == wio_pkg::WIO_ST_IDLE
                       && scanner_layout_mode
                       && ext_recv && !laser_emitting;
    wire [9:0] lay_num = (sync2_q.layout_num == `WIO_LAYOUT_ZERO)
                         ? `WIO_LAYOUT_MIN : sync2_q.layout_num;
    wire lay_look  = st_q == wio_pkg::WIO_ST_LOOK;
    wire lay_ok    = lay_look && mem_rdata;
    wire lay_bad   = lay_look && !mem_rdata;

    // Register bus decode
    wire apb_setup = psel && !penable;
    wire apb_acc   = psel && penable;
    wire apb_wr    = apb_acc && pwrite;
    wire hit_ctrl  = paddr == `WIO_OFF_CTRL;
    wire hit_stat  = paddr == `WIO_OFF_STATUS;
    wire hit_ist   = paddr == `WIO_OFF_IRQ_STAT;
    wire hit_imsk  = paddr == `WIO_OFF_IRQ_MASK;
    wire hit_lwr   = paddr == `WIO_OFF_LAYOUT_WR;
    wire hit_sch   = paddr == `WIO_OFF_SCHED;
    wire hit_any   = hit_ctrl | hit_stat | hit_ist | hit_imsk
                     | hit_lwr | hit_sch;
    wire clearing  = st_q == wio_pkg::WIO_ST_CLEAR;

    wire [31:0] status_w = {6'h00, active_q, 9'h000, init_done,
                            data_error_q, laser_emitting, ext_recv,
                            ready, diode_on_q, ext_mode};
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl_q :
        hit_stat ? status_w :
        hit_ist  ? {28'h0000000, irq_stat_q} :
        hit_imsk ? {28'h0000000, irq_mask_q} :
        hit_sch  ? {28'h0000000, sched_f} : 32'h00000000;

    // Events: shot end, monitor error, data error, layout taken
    wire [3:0] events = {lay_ok, lay_bad, monitor_err, shot_done};
    wire [3:0] w1c    = (apb_wr && hit_ist) ? pwdata[3:0] : 4'h0;

    // Layout table is cleared once after reset
    wire       mem_we    = clearing || (apb_wr && hit_lwr);
    wire [9:0] mem_waddr = clearing ? clr_addr_q : pwdata[9:0];
    wire       mem_wdata = clearing ? 1'b0 : pwdata[`WIO_LWR_FLAG];

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else if (ce)
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            tick_cnt_q <= 16'h0000;
        end
        else if (ce)
        begin
            tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            ctrl_q     <= `WIO_CTRL_RST;
            irq_mask_q <= `WIO_IRQ_RST;
            prdata_q   <= 32'h00000000;
        end
        else if (ce)
        begin
            if (apb_wr && hit_ctrl)
                ctrl_q <= pwdata & `WIO_CTRL_MASK;
            if (apb_wr && hit_imsk)
                irq_mask_q <= pwdata[3:0];
            if (apb_setup && !pwrite)
                prdata_q <= rd_mux;
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge clk)
    begin
        if (!rstn)
            irq_stat_q <= `WIO_IRQ_RST;
        else if (ce)
            irq_stat_q <= (irq_stat_q & ~w1c) | events;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            filt_prev_q <= 5'h00;
            filt_q      <= 5'h00;
            filt_cnt_q  <= 16'h0000;
        end
        else if (ce)
        begin
            if (filt_in != filt_prev_q)
            begin
                filt_prev_q <= filt_in;
                filt_cnt_q  <= acc_ticks(acc_sel) + 16'h0001;
            end
            else if (tick && filt_cnt_q == 16'h0001)
            begin
                filt_q     <= filt_prev_q;
                filt_cnt_q <= 16'h0000;
            end
            else if (tick && filt_cnt_q != 16'h0000)
            begin
                filt_cnt_q <= filt_cnt_q - 16'h0001;
            end
        end
    end

    // Start needs ready; data error does not block it
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            start_prev_q <= 1'b0;
            scan_start_q <= 1'b0;
        end
        else if (ce)
        begin
            start_prev_q <= start_f;
            scan_start_q <= start_rise && ready;
        end
    end

    // Preparation restarts at diode on and each shot
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            diode_on_q <= 1'b0;
            prep_cnt_q <= 16'h0000;
        end
        else if (ce)
        begin
            diode_on_q <= diode_req;
            if ((diode_req && !diode_on_q) || (shot_done && diode_on_q))
                prep_cnt_q <= ms_ticks(`WIO_PREP_MS);
            else if (!diode_on_q)
                prep_cnt_q <= 16'h0000;
            else if (tick && prep_cnt_q != 16'h0000)
                prep_cnt_q <= prep_cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            end_cnt_q <= 16'h0000;
            judge_q   <= 2'h0;
        end
        else if (ce)
        begin
            if (shot_done)
            begin
                end_cnt_q <= width_ticks(wid_sel) + 16'h0001;
                judge_q   <= {energy_high, energy_low};
            end
            else if (tick && end_cnt_q != 16'h0000)
            begin
                end_cnt_q <= end_cnt_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            err_cnt_q <= 16'h0000;
        else if (ce)
        begin
            if (monitor_err)
                err_cnt_q <= ms_ticks(`WIO_ERR_MIN_MS) + 16'h0001;
            else if (tick && err_cnt_q != 16'h0000)
                err_cnt_q <= err_cnt_q - 16'h0001;
        end
    end

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            wio_pkg::WIO_ST_CLEAR:
                if (clr_addr_q == 10'h3FF)
                    st_d = wio_pkg::WIO_ST_IDLE;
            wio_pkg::WIO_ST_IDLE:
                if (lay_accept)
                    st_d = wio_pkg::WIO_ST_LOOK;
            wio_pkg::WIO_ST_LOOK:
                st_d = wio_pkg::WIO_ST_IDLE;
            default:
                st_d = wio_pkg::WIO_ST_CLEAR;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st_q          <= wio_pkg::WIO_ST_CLEAR;
            clr_addr_q    <= 10'h000;
            strobe_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            st_q          <= st_d;
            strobe_prev_q <= sync2_q.layout_strobe;
            if (clearing)
                clr_addr_q <= clr_addr_q + 10'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pend_q   <= `WIO_LAYOUT_MIN;
            active_q <= `WIO_LAYOUT_MIN;
        end
        else if (ce)
        begin
            if (lay_accept)
                pend_q <= lay_num;
            if (lay_ok)
                active_q <= pend_q;
        end
    end

    // Error reset clears; a same-cycle new error wins
    always_ff @(posedge clk)
    begin
        if (!rstn)
            data_error_q <= 1'b0;
        else if (ce)
            data_error_q <= lay_bad
                            || (data_error_q && !sync2_q.error_reset);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            pin_o_q <= '0;
        else if (ce)
        begin
            pin_o_q.ext_control     <= ext_mode;
            pin_o_q.diode_on_status <= diode_on_q;
            pin_o_q.output_ready    <= ready;
            pin_o_q.end_pulse       <= end_cnt_q != 16'h0000;
            pin_o_q.judge_high      <= judge_q[1] && end_cnt_q != 16'h0000;
            pin_o_q.judge_low       <= judge_q[0] && end_cnt_q != 16'h0000;
            pin_o_q.monitor_error   <= err_cnt_q != 16'h0000;
            pin_o_q.ext_receivable  <= ext_recv;
            pin_o_q.laser_emitting  <= laser_emitting;
            pin_o_q.data_error      <= data_error_q;
        end
    end

    wio_layout_mem #(
        .AW (10),
        .DW (1)
    ) u_layout_mem (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .re    (lay_accept),
        .raddr (lay_num),
        .rdata (mem_rdata)
    );

    assign prdata           = prdata_q;
    assign pready           = apb_acc;
    assign pslverr          = apb_acc && !hit_any;
    assign irq              = |(irq_stat_q & irq_mask_q);
    assign pin_o            = pin_o_q;
    assign scan_start_pulse = scan_start_q;

endmodule : wio_sequencer

`default_nettype wire

/* File: verilog/wio_defines.svh */
`ifndef WIO_DEFINES_SVH
`define WIO_DEFINES_SVH

// Clock and the 0.1 ms timing tick
`define WIO_CLK_MHZ          200
`define WIO_TICK_US          100
`define WIO_TICK_CYC         (`WIO_TICK_US * `WIO_CLK_MHZ)

// Times in their own units, converted to ticks where used
`define WIO_PREP_MS          1000
`define WIO_ERR_MIN_MS       1
`define WIO_PULSE_20_MS      20
`define WIO_PULSE_30_MS      30
`define WIO_PULSE_40_MS      40
`define WIO_ACC_0_US         100
`define WIO_ACC_1_US         1000
`define WIO_ACC_2_US         2000
`define WIO_ACC_3_US         4000
`define WIO_ACC_4_US         8000
`define WIO_ACC_5_US         16000
`define WIO_US_PER_MS        1000

// Layout numbers
`define WIO_LAYOUT_MIN       10'h001
`define WIO_LAYOUT_ZERO      10'h000

// Register byte offsets
`define WIO_OFF_CTRL         8'h00
`define WIO_OFF_STATUS       8'h04
`define WIO_OFF_IRQ_STAT     8'h08
`define WIO_OFF_IRQ_MASK     8'h0C
`define WIO_OFF_LAYOUT_WR    8'h10
`define WIO_OFF_SCHED        8'h14

// Control register fields
`define WIO_CTRL_HOST_SRC    0
`define WIO_CTRL_HOST_EXT    1
`define WIO_CTRL_FRONT_DIODE 2
`define WIO_CTRL_LAYOUT_MODE 3
`define WIO_CTRL_ACC_LO      4
`define WIO_CTRL_ACC_HI      6
`define WIO_CTRL_WID_LO      8
`define WIO_CTRL_WID_HI      9
`define WIO_CTRL_MASK        32'h0000037F
`define WIO_CTRL_RST         32'h00000030

// Layout registration write fields
`define WIO_LWR_FLAG         16

// Status register layout field
`define WIO_STAT_LAYOUT_LO   16

// Interrupt status bits
`define WIO_IRQ_W            4
`define WIO_IRQ_RST          4'h0

`endif

/* File: verilog/wio_pkg.sv */
package wio_pkg;

    typedef struct packed {
        logic       ctrl_select;
        logic       diode_power_request;
        logic       scan_start;
        logic       layout_strobe;
        logic       error_reset;
        logic [3:0] schedule;
        logic [9:0] layout_num;
    } wio_pin_in_t;

    typedef struct packed {
        logic ext_control;
        logic diode_on_status;
        logic output_ready;
        logic end_pulse;
        logic judge_high;
        logic judge_low;
        logic monitor_error;
        logic ext_receivable;
        logic laser_emitting;
        logic data_error;
    } wio_pin_out_t;

    typedef enum logic [1:0] {
        WIO_ST_CLEAR,
        WIO_ST_IDLE,
        WIO_ST_LOOK
    } wio_lay_st_t;

endpackage : wio_pkg

/* File: verilog/wio_layout_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module wio_layout_mem #(
    parameter int AW = 10,
    parameter int DW = 1
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [DW-1:0] rdata_q;

    always_ff @(posedge clk)
    begin
        if (ce && we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata_q <= '0;
        end
        else if (ce && re)
        begin
            rdata_q <= mem[raddr];
        end
    end

    assign rdata = rdata_q;

endmodule : wio_layout_mem

`default_nettype wire

/* File: test/wio_sequencer_props.sv */
`timescale 1ns/1ps
`default_nettype none

module wio_seq_props #(
    parameter int unsigned TICK_CYC = 20000
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [7:0]            paddr,
    input wire logic                  pready,
    input wire logic                  pslverr,
    input wire wio_pkg::wio_pin_in_t  pin_i,
    input wire wio_pkg::wio_pin_out_t pin_o,
    input wire logic                  laser_emitting,
    input wire logic                  shot_done,
    input wire logic                  monitor_err,
    input wire logic                  scan_start_pulse
);
    logic [31:0] end_q, err_q;

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    always_ff @(posedge clk)
    begin
        end_q <= (rstn && pin_o.end_pulse) ? end_q + 32'h1 : 32'h0;
        err_q <= (rstn && pin_o.monitor_error) ? err_q + 32'h1 : 32'h0;
    end

    a_apb_zero_wait: assert property (psel && penable |-> pready)
        else $error("no pready");
    a_err_in_access: assert property (pslverr |-> psel && penable)
        else $error("stray pslverr");
    a_unmapped_err: assert property (psel && penable && paddr > 8'h14
        |-> pslverr) else $error("no pslverr");
    a_end_min_width: assert property ($fell(pin_o.end_pulse)
        |-> end_q >= 200 * TICK_CYC) else $error("short end pulse");
    a_end_cause: assert property ($rose(pin_o.end_pulse)
        |-> $past(shot_done, 2)) else $error("stray end pulse");
    a_err_min_width: assert property ($fell(pin_o.monitor_error)
        |-> err_q >= 10 * TICK_CYC) else $error("short error pulse");
    a_err_cause: assert property ($rose(pin_o.monitor_error)
        |-> $past(monitor_err, 2)) else $error("stray error pulse");
    a_strobe_gate: assert property ($rose(pin_o.data_error)
        |-> $past(pin_i.layout_strobe, 3) && !$past(laser_emitting, 3))
        else $error("stray data error");
    a_ready_diode: assert property ($rose(pin_o.output_ready)
        |-> pin_o.diode_on_status) else $error("ready without diode on");
    a_scan_single: assert property (scan_start_pulse |=> !scan_start_pulse)
        else $error("long scan start");
    a_error_holds: assert property ($fell(pin_o.data_error)
        |-> $past(pin_i.error_reset, 3)) else $error("data error lost");

    c_data_error: cover property ($rose(pin_o.data_error));
    c_scan: cover property ($rose(scan_start_pulse));
    c_end: cover property ($fell(pin_o.end_pulse));
    c_mon: cover property ($fell(pin_o.monitor_error));
endmodule : wio_seq_props

bind wio_sequencer wio_seq_props #(.TICK_CYC(TICK_CYC)) u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
    .pin_o(pin_o), .laser_emitting(laser_emitting),
    .shot_done(shot_done), .monitor_err(monitor_err),
    .scan_start_pulse(scan_start_pulse)
);

`default_nettype wire

/* File: test/wio_plc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module wio_plc_model (
    input  wire logic                  clk,
    input  wire wio_pkg::wio_pin_out_t pin_o,
    input  wire logic                  sel_ext,
    input  wire logic                  diode_cmd,
    input  wire logic                  scan_cmd,
    input  wire logic                  stb_cmd,
    input  wire logic                  err_cmd,
    input  wire logic [9:0]            lay_cmd,
    output wio_pkg::wio_pin_in_t       pin_i
);
    always @(posedge clk)
    begin
        pin_i.ctrl_select <= sel_ext;
        pin_i.diode_power_request <= diode_cmd
            | (pin_i.diode_power_request & pin_o.data_error);
        pin_i.scan_start <= scan_cmd
            & (pin_i.scan_start | pin_o.output_ready);
        pin_i.layout_strobe <= stb_cmd;
        pin_i.error_reset <= err_cmd;
        pin_i.schedule <= 4'h1;
        pin_i.layout_num <= lay_cmd;
    end
endmodule : wio_plc_model

`default_nettype wire

/* File: test/wio_sequencer_tb.sv */
`include "wio_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module wio_sequencer_tb;
    localparam int T = 4;
    logic                  clk, rstn, ce, psel, penable, pwrite;
    logic                  pready, pslverr, irq, e, eh, exp_err;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, q;
    logic                  laser_emitting, shot_done, energy_high;
    logic                  energy_low, monitor_err, scan_start_pulse;
    logic                  sel_ext, diode_cmd, scan_cmd, stb_cmd, err_cmd;
    logic [9:0]            lay_cmd;
    wio_pkg::wio_pin_in_t  pin_i;
    wio_pkg::wio_pin_out_t pin_o;
    int                    fail_count, cmp_count, n, exp_lay, r, u, nn;
    bit                    reg_tbl [1024];

    wio_sequencer #(.TICK_CYC(T)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .pin_i(pin_i), .pin_o(pin_o),
        .laser_emitting(laser_emitting), .shot_done(shot_done),
        .energy_high(energy_high), .energy_low(energy_low),
        .monitor_err(monitor_err), .scan_start_pulse(scan_start_pulse));

    wio_plc_model u_plc (.clk(clk), .pin_o(pin_o), .sel_ext(sel_ext),
        .diode_cmd(diode_cmd), .scan_cmd(scan_cmd), .stb_cmd(stb_cmd),
        .err_cmd(err_cmd), .lay_cmd(lay_cmd), .pin_i(pin_i));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wrap_up;
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic timed_out;
        fail_count++;
        $display("unexpected at %0t: timeout", $time);
        wrap_up();
    endtask : timed_out

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
            k++;
            if (k > 50)
                timed_out();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    wire [4:0] mon = {pin_o.monitor_error, pin_o.end_pulse,
                      scan_start_pulse, pin_o.ext_receivable,
                      pin_o.output_ready};

    task automatic wait_hi(input int w, input int lim);
        int k = 0;
        while (mon[w] !== 1'b1)
        begin
            @(posedge clk);
            k++;
            if (k > lim)
                timed_out();
        end
    endtask : wait_hi

    task automatic high_len(input int w, output int len);
        len = 0;
        while (mon[w] === 1'b1 && len < 9000)
        begin
            @(posedge clk);
            len++;
        end
    endtask : high_len

    task automatic strobe(input int a, input int b, input logic live);
        int m = (a == 0) ? 1 : a;
        if (live)
            wait_hi(1, 200);
        lay_cmd <= a[9:0];
        repeat (4) @(posedge clk);
        stb_cmd <= 1'b1;
        repeat (10) @(posedge clk);
        lay_cmd <= b[9:0];
        repeat (10) @(posedge clk);
        stb_cmd <= 1'b0;
        repeat (6) @(posedge clk);
        if (live && reg_tbl[m])
            exp_lay = m;
        else if (live)
            exp_err = 1'b1;
        apb(0, `WIO_OFF_STATUS, 0);
        check(q[25:16], exp_lay);
        check(pin_o.data_error, exp_err);
    endtask : strobe

    initial
    begin
        {rstn, psel, penable, pwrite, paddr, pwdata, lay_cmd} = '0;
        {laser_emitting, shot_done, energy_high, energy_low} = '0;
        {monitor_err, sel_ext, diode_cmd, scan_cmd, stb_cmd, err_cmd} = '0;
        ce = 1'b1;
        {fail_count, cmp_count} = '0;
        exp_lay = 1;
        exp_err = 1'b0;
        void'($urandom(78868));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        apb(0, `WIO_OFF_CTRL, 0);
        check(q, `WIO_CTRL_RST);
        apb(0, `WIO_OFF_IRQ_MASK, 0);
        check(q, 32'h0);
        apb(0, `WIO_OFF_STATUS, 0);
        check(q[25:16], 32'h1);
        apb(0, 8'h18, 32'hFFFFFFFF);
        check({e, q[30:0]}, 32'h80000000);
        r = $urandom;
        apb(1, `WIO_OFF_CTRL, r);
        apb(0, `WIO_OFF_CTRL, 0);
        check(q, r & `WIO_CTRL_MASK);
        n = 0;
        q = 32'h0;
        while (q[6] !== 1'b1)
        begin
            apb(0, `WIO_OFF_STATUS, 0);
            n++;
            if (n > 600)
                timed_out();
        end
        for (int i = 0; i < 8; i++)
        begin
            sel_ext <= i[0];
            apb(1, `WIO_OFF_CTRL, 32'h8 | (i >> 1));
            repeat (8) @(posedge clk);
            check(pin_o.ext_control, i[1] ? i[2] : i[0]);
        end
        apb(1, `WIO_OFF_CTRL, 32'h8);
        diode_cmd <= 1'b1;
        repeat (8) @(posedge clk);
        check(pin_o.diode_on_status, 32'h1);
        wait_hi(0, 10001 * T + 20);
        apb(0, `WIO_OFF_SCHED, 0);
        check(q, 32'h1);
        r = 2 + $urandom % 1022;
        u = (r == 1023) ? 1022 : r + 1;
        apb(1, `WIO_OFF_LAYOUT_WR, 32'h10001);
        apb(1, `WIO_OFF_LAYOUT_WR, 32'h10000 | r);
        apb(1, `WIO_OFF_LAYOUT_WR, u);
        reg_tbl[1] = 1'b1;
        reg_tbl[r] = 1'b1;
        apb(1, `WIO_OFF_IRQ_MASK, 32'h4);
        strobe(r, r, 1'b1);
        strobe(0, 0, 1'b1);
        strobe(r, r, 1'b1);
        strobe(u, u, 1'b1);
        check(irq, 32'h1);
        apb(1, `WIO_OFF_IRQ_MASK, 32'h0);
        check(irq, 32'h0);
        apb(1, `WIO_OFF_IRQ_MASK, 32'h4);
        check(irq, 32'h1);
        apb(1, `WIO_OFF_IRQ_STAT, 32'h4);
        apb(0, `WIO_OFF_IRQ_STAT, 0);
        check({irq, q[2]}, 32'h0);
        scan_cmd <= 1'b1;
        wait_hi(2, 200);
        check(scan_start_pulse, 32'h1);
        scan_cmd <= 1'b0;
        strobe(r, 1, 1'b1);
        laser_emitting <= 1'b1;
        strobe(1, 1, 1'b0);
        check(pin_o.laser_emitting, 32'h1);
        laser_emitting <= 1'b0;
        err_cmd <= 1'b1;
        repeat (10) @(posedge clk);
        err_cmd <= 1'b0;
        repeat (6) @(posedge clk);
        check(pin_o.data_error, 32'h0);
        for (int w = 0; w < 3; w++)
        begin
            nn = (200 + 100 * w) * T;
            apb(1, `WIO_OFF_CTRL, 32'h8 | (w << 8));
            eh = $urandom % 2;
            energy_high <= eh;
            energy_low <= !eh;
            shot_done <= 1'b1;
            @(posedge clk);
            shot_done <= 1'b0;
            wait_hi(3, 100);
            check({pin_o.judge_high, pin_o.judge_low}, {eh, !eh});
            high_len(3, n);
            check(n >= nn && n <= nn + T + 2, 32'h1);
        end
        monitor_err <= 1'b1;
        @(posedge clk);
        monitor_err <= 1'b0;
        wait_hi(4, 100);
        high_len(4, n);
        check(n >= 10 * T && n <= 11 * T + 2, 32'h1);
        diode_cmd <= 1'b0;
        repeat (8) @(posedge clk);
        check(pin_o.diode_on_status, 32'h0);
        wrap_up();
    end
endmodule : wio_sequencer_tb

`default_nettype wire
